// File: include/dpf_pkg.sv
// constants and types shared by the dual-partition flash controller
//
// Function
// - boot order word holds a 12-bit number low, its complement in bits 23:12.
// - at reset the partition with the lowest boot order number becomes active.
// - an invalid or unprogrammed number counts as 0x000FFF before comparing.
// - equal numbers, both invalid included, select partition 1 with no notice.
// - an uncorrectable double-bit error on either word requests the trap.
// - the swap instruction exchanges partitions without reset; a jump follows it.
// - a swap without a preceding unlock does nothing; the code still cancels a pending first key.
// - a swap leaves every other register and setting untouched; the code also spends the unlock.
// - bit 11 is set by a successful swap; software clears it before the next.
// - read-only bit 10 reads 1 while partition 2 is the active one.
// - protected mode forbids erase and write of partition 1.
// - privileged mode freezes the boot segment limit.
// - upper 8 and lower 16 address bits join into the 24-bit target.
// - row programming fetches data from RAM at the source pointer.
// - software-set-only bit 15 starts an operation; hardware clears it at the end.
// - bit 14 permits program and erase when 1, inhibits when 0.
// - clearable bit 13 flags an improper sequence or a terminated operation.
// - bit 12 puts the regulator in standby in idle; access waits a delay after.
// - bit 9 selects packed row data; clearable bit 8 flags a row underrun.
// - operation codes 0011 page erase, 0010 row, 0001 double-word, 0100, 1110.
package dpf_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T_VREG_NS     = 10000;
  localparam int unsigned VREG_CYCLES   = (T_VREG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_UNLOCK    = 8'h04;
  localparam logic [7:0] OFS_LOWER     = 8'h08;
  localparam logic [7:0] OFS_UPPER     = 8'h0C;
  localparam logic [7:0] OFS_SOURCE    = 8'h10;
  localparam logic [7:0] OFS_SEG_LIMIT = 8'h14;

  // control register fields
  localparam int unsigned BIT_GO      = 15;
  localparam int unsigned BIT_PERMIT  = 14;
  localparam int unsigned BIT_FAULT   = 13;
  localparam int unsigned BIT_IDLE_SB = 12;
  localparam int unsigned BIT_SWAPPED = 11;
  localparam int unsigned BIT_LIVE_P2 = 10;
  localparam int unsigned BIT_PACKED  = 9;
  localparam int unsigned BIT_STARVE  = 8;

  localparam logic [15:0] CONTROL_RESET   = 16'h0000;
  localparam logic [15:0] SEG_LIMIT_RESET = 16'h0000;

  localparam logic [7:0]  KEY_FIRST  = 8'h55;
  localparam logic [7:0]  KEY_SECOND = 8'hAA;
  localparam logic [11:0] ORDER_MAX  = 12'hFFF;
  localparam int unsigned INACTIVE_BIT = 22;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    OP_DWORD     = 4'h1,
    OP_ROW       = 4'h2,
    OP_PAGE      = 4'h3,
    OP_INACT_ERS = 4'h4,
    OP_BULK      = 4'hE
  } flash_action_t;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b11
  } ctl_state_t;

endpackage : dpf_pkg

// File: include/boot_order_if.sv
// carrier between the controller and its boot order comparator
`timescale 1ns/100ps
interface boot_order_if;
  logic [23:0] word_p1;
  logic [23:0] word_p2;
  logic        pick_p2;

  modport ctl  (output word_p1, output word_p2, input pick_p2);
  modport pick (input word_p1, input word_p2, output pick_p2);
endinterface : boot_order_if

// File: design/boot_order_pick.sv
// compares the two boot order words and names the partition to boot
`timescale 1ns/100ps
module boot_order_pick
  import dpf_pkg::*;
(
  boot_order_if.pick bo
);

  // a word is trusted only when its upper half is the exact complement
  function automatic logic [11:0] order_number(input logic [23:0] word);
    if (word[23:12] == ~word[11:0]) begin
      return word[11:0];
    end
    return ORDER_MAX;
  endfunction : order_number

  // strict less-than: ties fall to partition 1 silently
  assign bo.pick_p2 = order_number(bo.word_p2) < order_number(bo.word_p1);

endmodule : boot_order_pick

// File: design/dual_partition_flash_control.sv
// dual-partition flash controller with AXI4-Lite registers
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
module dual_partition_flash_control
  import dpf_pkg::*;
#(
  parameter int unsigned VREG_WAIT = VREG_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [23:0] boot_order_word_p1,
  input  wire logic [23:0] boot_order_word_p2,
  input  wire logic        boot_dbl_err_p1,
  input  wire logic        boot_dbl_err_p2,
  output logic             double_fault_trap,
  input  wire logic        partition_swap_instr,
  output logic             second_half_live,
  input  wire logic        protected_mode,
  input  wire logic        privileged_mode,
  output logic [15:0]      boot_segment_limit,
  input  wire logic        cpu_idle,
  output logic             regulator_standby,
  output logic             flash_ready,
  output logic             sleep_instr_block,
  output logic             flash_req,
  output logic [3:0]       flash_action_select,
  output logic [23:0]      flash_target,
  output logic [23:0]      row_source_pointer,
  output logic             row_packing_select,
  input  wire logic        flash_done,
  input  wire logic        flash_abort,
  input  wire logic        flash_underrun
);

  if (VREG_WAIT < 1 || VREG_WAIT > 65535) begin : g_check
    $error("VREG_WAIT must lie between 1 and 65535");
  end

  boot_order_if bo ();

  boot_order_pick u_pick (
    .bo (bo.pick)
  );

  assign bo.word_p1 = boot_order_word_p1;
  assign bo.word_p2 = boot_order_word_p2;

  ctl_state_t  state;
  logic        go;
  logic        permit;
  logic        seq_fault;
  logic        idle_sb;
  logic        swap_done;
  logic [3:0]  action;
  logic [15:0] lower_target;
  logic [7:0]  upper_target;
  logic        key_first;
  logic        armed;
  logic [15:0] vreg_cnt;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  ctl_state_t  next_state;
  logic        next_go;
  logic        next_permit;
  logic        next_seq_fault;
  logic        next_idle_sb;
  logic        next_swap_done;
  logic        next_live_p2;
  logic        next_packed;
  logic        next_starve;
  logic [3:0]  next_action;
  logic [15:0] next_lower;
  logic [7:0]  next_upper;
  logic [23:0] next_source;
  logic [15:0] next_seg_limit;
  logic        next_key_first;
  logic        next_armed;
  logic [15:0] next_vreg_cnt;
  logic        next_standby;
  logic        next_trap;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [1:0]  next_rresp;
  logic [31:0] next_rdata;

  logic        starve;
  logic        wr_fire;
  logic        rd_fire;
  logic        go_attempt;
  logic        go_ok;
  logic        swap_ok;
  logic [15:0] ctl_now;
  logic [15:0] ctl_new;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  function automatic logic action_known(input logic [3:0] code);
    return code inside {OP_DWORD, OP_ROW, OP_PAGE, OP_INACT_ERS, OP_BULK};
  endfunction : action_known

  // true when the operation would touch physical partition 1
  function automatic logic hits_first(input logic [3:0] code, input logic live_p2,
                                      input logic [23:0] target);
    if (code == OP_BULK) begin
      return 1'b1;
    end
    if (code == OP_INACT_ERS) begin
      return live_p2;
    end
    return ~(live_p2 ^ target[INACTIVE_BIT]);
  endfunction : hits_first

  function automatic logic mapped(input logic [7:0] addr);
    return addr inside {OFS_CONTROL, OFS_UNLOCK, OFS_LOWER, OFS_UPPER, OFS_SOURCE,
                        OFS_SEG_LIMIT};
  endfunction : mapped

  assign ctl_now = {go, permit, seq_fault, idle_sb, swap_done, second_half_live,
                    row_packing_select, starve, 4'h0, action};
  assign ctl_new = merge16(ctl_now, wdata, wstrb);

  // write address and data are taken together so no skid storage is needed
  assign awready = awvalid & wvalid & ~bvalid_q;
  assign wready  = awready;
  assign wr_fire = awready;
  assign arready = ~rvalid_q;
  assign rd_fire = arvalid & arready;

  assign go_attempt = wr_fire && awaddr == OFS_CONTROL && ctl_new[BIT_GO] && !go;
  assign go_ok = go_attempt && armed && permit && state == ST_IDLE
                 && action_known(action)
                 && !(protected_mode && hits_first(action, second_half_live, flash_target));
  // a swap landing in the same cycle as a bus write is dropped, and the unlock is cleared either way
  assign swap_ok = partition_swap_instr && armed && !wr_fire;

  always_comb begin
    next_state     = state;
    next_go        = go;
    next_permit    = permit;
    next_seq_fault = seq_fault;
    next_idle_sb   = idle_sb;
    next_swap_done = swap_done;
    next_live_p2   = second_half_live;
    next_packed    = row_packing_select;
    next_starve    = starve;
    next_action    = action;
    next_lower     = lower_target;
    next_upper     = upper_target;
    next_source    = row_source_pointer;
    next_seg_limit = boot_segment_limit;
    next_key_first = key_first;
    next_armed     = armed;
    next_trap      = 1'b0;
    next_bvalid    = bvalid_q;
    next_bresp     = bresp_q;
    next_rvalid    = rvalid_q;
    next_rresp     = rresp_q;
    next_rdata     = rdata_q;

    if (state == ST_BOOT) begin
      next_live_p2 = bo.pick_p2;
      next_trap    = boot_dbl_err_p1 | boot_dbl_err_p2;
      next_state   = ST_IDLE;
    end

    if (wr_fire) begin
      next_bvalid    = 1'b1;
      next_bresp     = mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
      // any write other than the key pair spends or cancels the unlock
      next_armed     = 1'b0;
      next_key_first = 1'b0;
      unique case (awaddr)
        OFS_CONTROL: begin
          next_permit  = ctl_new[BIT_PERMIT];
          next_idle_sb = ctl_new[BIT_IDLE_SB];
          if (state != ST_BUSY) begin
            next_packed = ctl_new[BIT_PACKED];
            next_action = ctl_new[3:0];
          end
          if (!ctl_new[BIT_FAULT]) begin
            next_seq_fault = 1'b0;
          end
          if (!ctl_new[BIT_SWAPPED]) begin
            next_swap_done = 1'b0;
          end
          if (!ctl_new[BIT_STARVE]) begin
            next_starve = 1'b0;
          end
        end
        OFS_UNLOCK: begin
          if (wstrb[0] && wdata[7:0] == KEY_FIRST) begin
            next_key_first = 1'b1;
          end else if (wstrb[0] && wdata[7:0] == KEY_SECOND && key_first) begin
            next_armed = 1'b1;
          end
        end
        OFS_LOWER: begin
          next_lower = merge16(lower_target, wdata, wstrb);
        end
        OFS_UPPER: begin
          if (wstrb[0]) begin
            next_upper = wdata[7:0];
          end
        end
        OFS_SOURCE: begin
          for (int i = 0; i < 3; i++) begin
            if (wstrb[i]) begin
              next_source[i*8 +: 8] = wdata[i*8 +: 8];
            end
          end
        end
        OFS_SEG_LIMIT: begin
          if (!privileged_mode) begin
            next_seg_limit = merge16(boot_segment_limit, wdata, wstrb);
          end
        end
        default: begin
        end
      endcase
    end
    if (bvalid_q && bready) begin
      next_bvalid = 1'b0;
    end

    if (go_attempt) begin
      if (go_ok) begin
        next_go    = 1'b1;
        next_state = ST_BUSY;
      end else begin
        next_seq_fault = 1'b1;
      end
    end

    if (partition_swap_instr) begin
      next_armed     = 1'b0;
      next_key_first = 1'b0;
    end
    // only the mapping and the done flag move here; the unlock was already cleared above
    if (swap_ok) begin
      next_live_p2   = ~second_half_live;
      next_swap_done = 1'b1;
    end

    if (state == ST_BUSY && (flash_done || flash_abort)) begin
      next_go    = 1'b0;
      next_state = ST_IDLE;
      if (flash_abort || flash_underrun) begin
        next_seq_fault = 1'b1;
      end
      if (flash_underrun) begin
        next_starve = 1'b1;
      end
    end

    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (araddr)
        OFS_CONTROL:   next_rdata = {16'h0000, ctl_now};
        OFS_LOWER:     next_rdata = {16'h0000, lower_target};
        OFS_UPPER:     next_rdata = {24'h000000, upper_target};
        OFS_SOURCE:    next_rdata = {8'h00, row_source_pointer};
        OFS_SEG_LIMIT: next_rdata = {16'h0000, boot_segment_limit};
        default:       next_rdata = 32'h0000_0000;
      endcase
    end else if (rvalid_q && rready) begin
      next_rvalid = 1'b0;
    end
  end

  // regulator wake-up delay restarts every time standby is left
  always_comb begin
    next_standby  = cpu_idle & idle_sb;
    next_vreg_cnt = vreg_cnt;
    if (regulator_standby) begin
      next_vreg_cnt = VREG_WAIT[15:0];
    end else if (vreg_cnt != 16'h0000) begin
      next_vreg_cnt = vreg_cnt - 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state              <= ST_BOOT;
      go                 <= CONTROL_RESET[BIT_GO];
      permit             <= CONTROL_RESET[BIT_PERMIT];
      seq_fault          <= CONTROL_RESET[BIT_FAULT];
      idle_sb            <= CONTROL_RESET[BIT_IDLE_SB];
      swap_done          <= CONTROL_RESET[BIT_SWAPPED];
      second_half_live   <= CONTROL_RESET[BIT_LIVE_P2];
      row_packing_select <= CONTROL_RESET[BIT_PACKED];
      starve             <= CONTROL_RESET[BIT_STARVE];
      action             <= CONTROL_RESET[3:0];
      lower_target       <= 16'h0000;
      upper_target       <= 8'h00;
      row_source_pointer <= 24'h000000;
      boot_segment_limit <= SEG_LIMIT_RESET;
      key_first          <= 1'b0;
      armed              <= 1'b0;
      vreg_cnt           <= 16'h0000;
      regulator_standby  <= 1'b0;
      double_fault_trap  <= 1'b0;
      bvalid_q           <= 1'b0;
      bresp_q            <= RESP_OKAY;
      rvalid_q           <= 1'b0;
      rresp_q            <= RESP_OKAY;
      rdata_q            <= 32'h0000_0000;
    end else begin
      state              <= next_state;
      go                 <= next_go;
      permit             <= next_permit;
      seq_fault          <= next_seq_fault;
      idle_sb            <= next_idle_sb;
      swap_done          <= next_swap_done;
      second_half_live   <= next_live_p2;
      row_packing_select <= next_packed;
      starve             <= next_starve;
      action             <= next_action;
      lower_target       <= next_lower;
      upper_target       <= next_upper;
      row_source_pointer <= next_source;
      boot_segment_limit <= next_seg_limit;
      key_first          <= next_key_first;
      armed              <= next_armed;
      vreg_cnt           <= next_vreg_cnt;
      regulator_standby  <= next_standby;
      double_fault_trap  <= next_trap;
      bvalid_q           <= next_bvalid;
      bresp_q            <= next_bresp;
      rvalid_q           <= next_rvalid;
      rresp_q            <= next_rresp;
      rdata_q            <= next_rdata;
    end
  end

  assign bvalid              = bvalid_q;
  assign bresp               = bresp_q;
  assign rvalid              = rvalid_q;
  assign rresp               = rresp_q;
  assign rdata               = rdata_q;
  assign flash_target        = {upper_target, lower_target};
  assign flash_action_select = action;
  assign flash_ready         = !regulator_standby && vreg_cnt == 16'h0000;
  // the engine reads RAM from the source pointer only while a request stands
  assign flash_req           = state == ST_BUSY && flash_ready;
  assign sleep_instr_block   = state == ST_BUSY;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // checker-side memory of the last accepted write, so any gap between keys is covered
  logic key_one_seen;
  logic next_key_one_seen;

  assign next_key_one_seen = (wr_fire || partition_swap_instr) ?
      (wr_fire && !partition_swap_instr && awaddr == OFS_UNLOCK && wstrb[0]
       && wdata[7:0] == KEY_FIRST) : key_one_seen;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_one_seen <= 1'b0;
    end else begin
      key_one_seen <= next_key_one_seen;
    end
  end

  sequence s_key_first_seen;
    key_one_seen && !partition_swap_instr;
  endsequence

  sequence s_key_pair;
    s_key_first_seen ##0 wr_fire && awaddr == OFS_UNLOCK && wdata[7:0] == KEY_SECOND
    && wstrb[0];
  endsequence

  sequence s_swap_taken;
    partition_swap_instr && armed && !wr_fire;
  endsequence

  a_key_arms: assert property (s_key_pair |=> armed)
    else $error("key pair did not unlock");
  a_go_unlocked: assert property ($rose(go) |-> $past(armed) && $past(permit))
    else $error("operation started without unlock or permit");
  a_bad_go_fault: assert property (go_attempt && !armed |=> seq_fault && !go)
    else $error("improper start not flagged");
  a_go_clears: assert property (state == ST_BUSY && flash_done |=> !go ##1 !flash_req)
    else $error("go bit not cleared at completion");
  a_swap_flips: assert property (s_swap_taken |=>
      second_half_live != $past(second_half_live) && swap_done
      && $stable(permit) && $stable(action))
    else $error("swap did not take effect");
  a_swap_nop: assert property (partition_swap_instr && !armed |=> $stable(second_half_live))
    else $error("locked swap changed the partition");
  // the releasing edge still samples reset low, so its attempt is left out
  a_boot_pick: assert property (aresetn && state == ST_BOOT |=>
      second_half_live == $past(bo.pick_p2) && state == ST_IDLE)
    else $error("boot partition not taken from comparison");
  a_boot_trap: assert property (aresetn && state == ST_BOOT
      && (boot_dbl_err_p1 || boot_dbl_err_p2) |=> double_fault_trap ##1 !double_fault_trap)
    else $error("double fault trap not requested once");
  a_first_guard: assert property ($rose(go) && $past(protected_mode) |->
      !$past(hits_first(action, second_half_live, flash_target)))
    else $error("protected partition targeted");
  a_limit_frozen: assert property (privileged_mode |=> $stable(boot_segment_limit))
    else $error("segment limit changed in privileged mode");
  a_regulator_wait: assert property ($fell(regulator_standby) |-> !flash_ready[*8])
    else $error("flash ready before regulator delay");

endmodule : dual_partition_flash_control

// File: tb/tb.sv
// self-checking bench for the dual-partition flash controller
`timescale 1ns/100ps
module tb;
  import dpf_pkg::*;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
  logic        rready = 0, swp = 0, prot = 0, priv = 0, idle = 0, done = 0, abrt = 0, und = 0;
  logic        e1 = 0, e2 = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic [3:0]  wstrb = 4'hF;
  logic [23:0] w1 = 0, w2 = 0, pa[6], pb[6];
  logic [1:0]  r;
  wire         awready, wready, bvalid, arready, rvalid, trap, live, req, rdy, sb, blk, pack;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [15:0] lim;
  wire  [3:0]  act;
  wire  [23:0] tgt, src;
  int          fail_count = 0, compares = 0, cyc = 0, traps = 0, ctl, lv, n1, n2;
  flash_action_t ops[5] = '{OP_DWORD, OP_ROW, OP_PAGE, OP_INACT_ERS, OP_BULK};

  dual_partition_flash_control #(.VREG_WAIT(10)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .boot_order_word_p1(w1), .boot_order_word_p2(w2), .boot_dbl_err_p1(e1),
    .boot_dbl_err_p2(e2), .double_fault_trap(trap), .partition_swap_instr(swp),
    .second_half_live(live), .protected_mode(prot), .privileged_mode(priv),
    .boot_segment_limit(lim), .cpu_idle(idle), .regulator_standby(sb), .flash_ready(rdy),
    .sleep_instr_block(blk), .flash_req(req), .flash_action_select(act),
    .flash_target(tgt), .row_source_pointer(src), .row_packing_select(pack),
    .flash_done(done), .flash_abort(abrt), .flash_underrun(und));

  always #10 aclk = ~aclk;

  // the trap is a one-cycle pulse, so count it rather than look for it
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (trap === 1'b1) traps <= traps + 1;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    #1 while (!(awready && wready)) begin @(posedge aclk); #1; end
    @(posedge aclk);
    awvalid <= 1'b0; wvalid <= 1'b0;
    #1 while (!bvalid) begin @(posedge aclk); #1; end
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    #1 while (!arready) begin @(posedge aclk); #1; end
    @(posedge aclk);
    arvalid <= 1'b0;
    #1 while (!rvalid) begin @(posedge aclk); #1; end
    r = rresp;
    d = rdata;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd

  task automatic unlock();
    wr(OFS_UNLOCK, KEY_FIRST);
    wr(OFS_UNLOCK, KEY_SECOND);
  endtask : unlock

  // drives {underrun, abort, done} for one cycle
  task automatic engine(input logic [2:0] m);
    @(posedge aclk);
    {und, abrt, done} <= m;
    @(posedge aclk);
    {und, abrt, done} <= 3'b000;
  endtask : engine

  task automatic swap();
    @(posedge aclk);
    swp <= 1'b1;
    @(posedge aclk);
    swp <= 1'b0;
    repeat (2) @(posedge aclk);
    #1;
  endtask : swap

  function automatic int eff(input logic [23:0] w);
    return (w[23:12] == ~w[11:0]) ? int'(w[11:0]) : 'hFFF;
  endfunction : eff

  function automatic logic [23:0] mk(input int n);
    return {~n[11:0], n[11:0]};
  endfunction : mk

  task automatic boot(input logic [23:0] a, input logic [23:0] b, input logic [1:0] e);
    int t;
    @(posedge aclk);
    aresetn <= 1'b0; w1 <= a; w2 <= b; {e2, e1} <= e;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t = traps;
    repeat (4) @(posedge aclk);
    #1 lv = int'(eff(b) < eff(a));
    ctl = lv << 10;
    chk(live, lv);
    chk(traps - t, |e);
    rd(OFS_CONTROL);
    chk(d, ctl);
  endtask : boot

  initial begin
    void'($urandom(46));
    n1 = $urandom;
    n2 = $urandom;
    // unprogrammed, mismatched complement, equal and random words
    pa = '{mk(5), mk(3), 24'hFFFFFF, 24'h123456, mk(n1), mk(7)};
    pb = '{mk(3), mk(5), mk('hFFE), 24'h000000, mk(n2), mk(7)};
    for (int i = 0; i < 6; i++) begin
      boot(pa[i], pb[i], (i == 5) ? 2'b01 : (i == 4) ? 2'b10 : 2'b00);
    end
    wr(8'h40, 0);
    chk(r, RESP_SLVERR);
    rd(8'h40);
    chk(r, RESP_SLVERR);
    rd(OFS_UNLOCK);
    chk(d, 0);
    wr(OFS_LOWER, n1);
    wr(OFS_UPPER, n1 >> 16);
    chk(tgt, n1 & 'hFFFFFF);
    wr(OFS_SOURCE, n2);
    chk(src, n2 & 'hFFFFFF);
    foreach (ops[i]) begin
      ctl = 'h4200 | ops[i] | (lv << 10);
      wr(OFS_CONTROL, ctl);
      unlock();
      wr(OFS_CONTROL, ctl | 'h8000);
      #1 chk(act, ops[i]);
      chk({req, blk, pack}, 3'b111);
      rd(OFS_CONTROL);
      chk(d, ctl | 'h8000);
      engine(3'b001);
      rd(OFS_CONTROL);
      #1 chk(d, ctl);
      chk(req, 0);
    end
    ctl = 'h4200 | OP_ROW | (lv << 10);
    wr(OFS_CONTROL, ctl);
    unlock();
    wr(OFS_CONTROL, ctl | 'h8000);
    engine(3'b110);
    rd(OFS_CONTROL);
    chk(d, ctl | 'h2100);
    wr(OFS_CONTROL, ctl);
    unlock();
    wr(OFS_LOWER, n1);
    wr(OFS_CONTROL, ctl | 'h8000);
    rd(OFS_CONTROL);
    chk(d, ctl | 'h2000);
    wr(OFS_CONTROL, 'h4208);
    unlock();
    wr(OFS_CONTROL, 'hC208);
    rd(OFS_CONTROL);
    chk(d, 'h6208);
    @(posedge aclk) prot <= 1'b1;
    ctl = 'h4200 | OP_PAGE | (lv << 10);
    wr(OFS_CONTROL, ctl);
    wr(OFS_UPPER, lv << 6);
    unlock();
    wr(OFS_CONTROL, ctl | 'h8000);
    rd(OFS_CONTROL);
    #1 chk(d, ctl | 'h2000);
    chk(req, 0);
    wr(OFS_CONTROL, ctl);
    wr(OFS_UPPER, (lv ^ 1) << 6);
    unlock();
    wr(OFS_CONTROL, ctl | 'h8000);
    #1 chk(req, 1);
    engine(3'b001);
    @(posedge aclk) {prot, priv} <= 2'b01;
    wr(OFS_SEG_LIMIT, n2);
    #1 chk(lim, 0);
    @(posedge aclk) priv <= 1'b0;
    wr(OFS_SEG_LIMIT, n2);
    #1 chk(lim, n2 & 'hFFFF);
    swap();
    chk(live, lv);
    unlock();
    swap();
    lv = 1 - lv;
    chk(live, lv);
    ctl = (ctl ^ 'h400) | 'h800;
    rd(OFS_CONTROL);
    chk(d, ctl);
    ctl = (ctl & ~'h800) | 'h1000;
    wr(OFS_CONTROL, ctl);
    rd(OFS_CONTROL);
    chk(d, ctl);
    @(posedge aclk) idle <= 1'b1;
    repeat (3) @(posedge aclk);
    #1 chk({sb, rdy}, 2'b10);
    @(posedge aclk) idle <= 1'b0;
    repeat (3) @(posedge aclk);
    #1 chk(rdy, 0);
    repeat (14) @(posedge aclk);
    #1 chk(rdy, 1);
    stop_test();
  end
endmodule : tb
